// File: verilog/clock_source_aux_consts.vh
`ifndef CLOCK_SOURCE_AUX_CONSTS_VH
`define CLOCK_SOURCE_AUX_CONSTS_VH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define OFS_CTRL1        3'h0
`define OFS_CTRL2        3'h1
`define OFS_TRIM         3'h2
`define OFS_CTRL4        3'h3
`define OFS_STATUS       3'h4

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define C1_CLKSEL_HI     7
`define C1_CLKSEL_LO     6
`define C1_REF_DIVIDER_HI       5
`define C1_REF_DIVIDER_LO       3
`define C1_REF_INT       2
`define C1_IRC_OE        1
`define C1_IRC_STOP      0
`define C2_BUS_CLOCK_DIVIDER_HI       7
`define C2_BUS_CLOCK_DIVIDER_LO       5
`define C2_LP            4
`define C4_LOL_IE        7
`define C4_CME           5
`define C4_FTRIM         0
`define ST_LOL           7
`define ST_LOCKED        6
`define ST_MON_ERR       5
`define ST_FF_VALID      4
`define ST_MODE_HI       3
`define ST_MODE_LO       1

// --------------------------------------------------------------
// Reset values and encodings
// --------------------------------------------------------------
`define RST_CTRL1        8'h04
`define RST_CTRL2        8'h20
`define SEL_FLL          2'h0
`define SEL_INT          2'h1
`define SEL_EXT          2'h2

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define CLK_PERIOD_NS    4
`define MON_TIMEOUT_NS   32000
`define FLL_FACTOR       1024
`define FLL_TOLERANCE    16
`define IRC_BASE_PERIOD  10'h040

`endif

// File: verilog/tick_divider.v
`timescale 1ns/10ps
// Divides an enable pulse stream by period_in plus one
module tick_divider #(
  parameter W = 10
) (
  input  wire         clk_in,
  input  wire         rst_b_in,
  input  wire         tick_in,
  input  wire         restart_in,
  input  wire [W-1:0] period_in,
  output reg          pulse_out
);

  reg [W-1:0] count_q;

  // Counter compares with current period so a new value acts at once
  always @(posedge clk_in) begin
    if (!rst_b_in || restart_in) begin
      count_q   <= {W{1'b0}};
      pulse_out <= 1'b0;
    end else if (tick_in) begin
      if (count_q >= period_in) begin
        count_q   <= {W{1'b0}};
        pulse_out <= 1'b1;
      end else begin
        count_q   <= count_q + {{(W-1){1'b0}}, 1'b1};
        pulse_out <= 1'b0;
      end
    end else begin
      pulse_out <= 1'b0;
    end
  end

endmodule // tick_divider

// File: verilog/clock_source_aux_control.v
`timescale 1ns/10ps
`include "clock_source_aux_consts.vh"
module clock_source_aux_control #(
  parameter MON_TIMEOUT_CYCLES = (`MON_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire       clk_in,
  input  wire       rst_b_in,
  input  wire       por_b_in,
  input  wire [2:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  input  wire [8:0] factory_trim_in,
  input  wire       debug_mode_in,
  input  wire       stop_in,
  input  wire       range_high_in,
  input  wire       ext_ref_tick_in,
  input  wire       fll_tick_in,
  output reg        main_output_clock_out,
  output reg        irc_output_clock_out,
  output reg        fixed_freq_clock_out,
  output reg        ffclk_valid_out,
  output reg        fll_enable_out,
  output reg        dco_up_out,
  output reg        dco_down_out,
  output reg        irq_out,
  output reg        reset_request_out,
  output reg        osc_enable_request_out
);

  // ------------------------------------------------------------
  // Modes
  // ------------------------------------------------------------
  localparam [2:0] MODE_FEI   = 3'h0;
  localparam [2:0] MODE_FEE   = 3'h1;
  localparam [2:0] MODE_FBI   = 3'h2;
  localparam [2:0] MODE_INTERNAL_LOWPOWER_BYPASS_MODE = 3'h3;
  localparam [2:0] MODE_FBE   = 3'h4;
  localparam [2:0] MODE_EXTERNAL_LOWPOWER_BYPASS_MODE = 3'h5;
  localparam [10:0] LOCK_LO = `FLL_FACTOR - `FLL_TOLERANCE;
  localparam [10:0] LOCK_HI = `FLL_FACTOR + `FLL_TOLERANCE;
  localparam [15:0] MON_LIMIT = MON_TIMEOUT_CYCLES[15:0];
  localparam [7:0]  RST_C1    = `RST_CTRL1;
  localparam [7:0]  RST_C2    = `RST_CTRL2;

  // Mode from select, reference choice, power-down and debug
  function [2:0] decode_mode;
    input [1:0] sel;
    input       ref_int;
    input       lp;
    input       dbg;
    reg         low_pwr;
    begin
      low_pwr = lp & ~dbg;
      case (sel)
        `SEL_INT: decode_mode = low_pwr ? MODE_INTERNAL_LOWPOWER_BYPASS_MODE : MODE_FBI;
        `SEL_EXT: decode_mode = low_pwr ? MODE_EXTERNAL_LOWPOWER_BYPASS_MODE : MODE_FBE;
        default:  decode_mode = ref_int ? MODE_FEI : MODE_FEE;
      endcase
    end
  endfunction

  // Modes whose reference is the external one
  function is_external;
    input [2:0] m;
    begin
      is_external = (m == MODE_FEE) || (m == MODE_FBE) || (m == MODE_EXTERNAL_LOWPOWER_BYPASS_MODE);
    end
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [1:0]  clock_source_select_q;
  reg  [2:0]  ref_divider_q;
  reg         ref_select_internal_q;
  reg         irc_output_enable_q;
  reg         irc_stop_enable_q;
  reg  [2:0]  bus_clock_divider_q;
  reg         fll_bypass_power_down_q;
  reg  [7:0]  coarse_trim_q;
  reg         fine_trim_q;
  reg         loss_of_lock_irq_enable_q;
  reg         clock_monitor_enable_q;
  reg         loss_of_lock_flag_q;
  reg         monitor_error_q;
  reg         locked_q;
  reg  [10:0] fll_count_q;
  reg  [15:0] mon_count_q;
  reg         mon_fire_q;

  wire [2:0]  mode;
  wire        ext_mode;
  wire        low_power_mode;
  wire        wr_c1;
  wire        wr_c2;
  wire        wr_st;
  wire        irc_run;
  wire        irc_pulse;
  wire        ref_pulse;
  wire        src_tick;
  wire        main_pulse;
  wire        lock_ref;
  wire        lock_active;
  wire        in_window;
  wire        lol_event;
  wire        mon_enabled;
  wire        ff_ok;
  wire [9:0]  irc_period;
  wire [9:0]  ref_period;
  wire [9:0]  bus_period;

  assign mode           = decode_mode(clock_source_select_q, ref_select_internal_q,
                                      fll_bypass_power_down_q, debug_mode_in);
  assign ext_mode       = is_external(mode);
  assign low_power_mode = (mode == MODE_INTERNAL_LOWPOWER_BYPASS_MODE) || (mode == MODE_EXTERNAL_LOWPOWER_BYPASS_MODE);
  assign wr_c1          = wr_in && (addr_in == `OFS_CTRL1);
  assign wr_c2          = wr_in && (addr_in == `OFS_CTRL2);
  assign wr_st          = wr_in && (addr_in == `OFS_STATUS);

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      clock_source_select_q     <= RST_C1[`C1_CLKSEL_HI:`C1_CLKSEL_LO];
      ref_divider_q             <= RST_C1[`C1_REF_DIVIDER_HI:`C1_REF_DIVIDER_LO];
      ref_select_internal_q     <= RST_C1[`C1_REF_INT];
      irc_output_enable_q       <= RST_C1[`C1_IRC_OE];
      irc_stop_enable_q         <= RST_C1[`C1_IRC_STOP];
      bus_clock_divider_q       <= RST_C2[`C2_BUS_CLOCK_DIVIDER_HI:`C2_BUS_CLOCK_DIVIDER_LO];
      fll_bypass_power_down_q   <= RST_C2[`C2_LP];
      coarse_trim_q             <= factory_trim_in[8:1];
      fine_trim_q               <= factory_trim_in[0];
      loss_of_lock_irq_enable_q <= 1'b0;
      clock_monitor_enable_q    <= 1'b0;
    end else if (wr_in) begin
      case (addr_in)
        `OFS_CTRL1: begin
          clock_source_select_q <= wdata_in[`C1_CLKSEL_HI:`C1_CLKSEL_LO];
          ref_divider_q         <= wdata_in[`C1_REF_DIVIDER_HI:`C1_REF_DIVIDER_LO];
          ref_select_internal_q <= wdata_in[`C1_REF_INT];
          irc_output_enable_q   <= wdata_in[`C1_IRC_OE];
          irc_stop_enable_q     <= wdata_in[`C1_IRC_STOP];
        end
        `OFS_CTRL2: begin
          bus_clock_divider_q     <= wdata_in[`C2_BUS_CLOCK_DIVIDER_HI:`C2_BUS_CLOCK_DIVIDER_LO];
          fll_bypass_power_down_q <= wdata_in[`C2_LP];
        end
        `OFS_TRIM: begin
          coarse_trim_q <= wdata_in;
        end
        `OFS_CTRL4: begin
          loss_of_lock_irq_enable_q <= wdata_in[`C4_LOL_IE];
          clock_monitor_enable_q    <= wdata_in[`C4_CME];
          fine_trim_q               <= wdata_in[`C4_FTRIM];
        end
        default: begin
          coarse_trim_q <= coarse_trim_q;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_b_in || !rd_in) begin
      rdata_out <= 8'h00;
    end else begin
      case (addr_in)
        `OFS_CTRL1:  rdata_out <= {clock_source_select_q, ref_divider_q,
                                   ref_select_internal_q, irc_output_enable_q,
                                   irc_stop_enable_q};
        `OFS_CTRL2:  rdata_out <= {bus_clock_divider_q, fll_bypass_power_down_q, 4'h0};
        `OFS_TRIM:   rdata_out <= coarse_trim_q;
        `OFS_CTRL4:  rdata_out <= {loss_of_lock_irq_enable_q, 1'b0,
                                   clock_monitor_enable_q, 4'h0, fine_trim_q};
        `OFS_STATUS: rdata_out <= {loss_of_lock_flag_q, locked_q, monitor_error_q,
                                   ff_ok, mode, 1'b0};
        default:     rdata_out <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Internal reference oscillator
  // ------------------------------------------------------------
  // keeps running in stop when both bits set
  assign irc_run    = ~stop_in | (irc_output_enable_q & irc_stop_enable_q);
  assign irc_period = `IRC_BASE_PERIOD + {1'b0, coarse_trim_q, 1'b0}
                      + {9'h000, fine_trim_q};

  tick_divider #(.W(10)) irc_div (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .tick_in    (irc_run),
    .restart_in (1'b0),
    .period_in  (irc_period),
    .pulse_out  (irc_pulse)
  );

  // internal reference on its own output
  always @(posedge clk_in) begin
    if (!rst_b_in || !irc_output_enable_q) begin
      irc_output_clock_out <= 1'b0;
    end else if (irc_pulse) begin
      irc_output_clock_out <= ~irc_output_clock_out;
    end
  end

  // ------------------------------------------------------------
  // Reference divider and fixed-frequency clock
  // ------------------------------------------------------------
  assign ref_period = (10'h001 << ref_divider_q) - 10'h001;

  tick_divider #(.W(10)) ref_div (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .tick_in    (ext_ref_tick_in & ~stop_in),
    .restart_in (wr_c1),
    .period_in  (ref_period),
    .pulse_out  (ref_pulse)
  );

  // bypass validity: external only, divider floor
  assign ff_ok = (mode == MODE_FEI) || (mode == MODE_FEE) ||
                 (((mode == MODE_FBE) || (mode == MODE_EXTERNAL_LOWPOWER_BYPASS_MODE)) &&
                  (!range_high_in ||
                   ((bus_clock_divider_q <= 3'h3) &&
                    ({1'b0, ref_divider_q} >= {1'b0, bus_clock_divider_q} + 4'h2))));

  // divided reference out ungated, validity registered beside it
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      fixed_freq_clock_out <= 1'b0;
      ffclk_valid_out      <= 1'b0;
    end else begin
      ffclk_valid_out <= ff_ok;
      if (ref_pulse) begin
        fixed_freq_clock_out <= ~fixed_freq_clock_out;
      end
    end
  end

  // ------------------------------------------------------------
  // Main output clock
  // ------------------------------------------------------------
  // internal bypass modes follow the trimmed reference
  assign src_tick = ~stop_in &
                    ((clock_source_select_q == `SEL_INT) ? irc_pulse :
                     (clock_source_select_q == `SEL_EXT) ? ext_ref_tick_in :
                     fll_tick_in);
  assign bus_period = (10'h001 << bus_clock_divider_q) - 10'h001;

  // new divider used at once, count restarted
  tick_divider #(.W(10)) bus_div (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .tick_in    (src_tick),
    .restart_in (wr_c2),
    .period_in  (bus_period),
    .pulse_out  (main_pulse)
  );

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      main_output_clock_out <= 1'b0;
    end else begin
      main_output_clock_out <= main_pulse;
    end
  end

  // ------------------------------------------------------------
  // FLL enable and lock detection
  // ------------------------------------------------------------
  // external reference in external modes
  assign lock_ref    = ext_mode ? ref_pulse : irc_pulse;
  assign lock_active = ~low_power_mode & ~stop_in;
  assign in_window   = (fll_count_q >= LOCK_LO) && (fll_count_q <= LOCK_HI);
  assign lol_event   = lock_active & lock_ref & locked_q & ~in_window;

  // count DCO ticks per reference tick against 1024
  always @(posedge clk_in) begin
    if (!rst_b_in || !lock_active) begin
      fll_count_q    <= 11'h000;
      locked_q       <= 1'b0;
      dco_up_out     <= 1'b0;
      dco_down_out   <= 1'b0;
      fll_enable_out <= 1'b0;
    end else begin
      // FLL off in low-power bypass and in stop
      fll_enable_out <= 1'b1;
      if (lock_ref) begin
        fll_count_q  <= {10'h000, fll_tick_in};
        locked_q     <= in_window;
        dco_up_out   <= (fll_count_q < `FLL_FACTOR);
        dco_down_out <= (fll_count_q > `FLL_FACTOR);
      end else begin
        dco_up_out   <= 1'b0;
        dco_down_out <= 1'b0;
        if (fll_tick_in && fll_count_q != 11'h7ff) begin
          fll_count_q <= fll_count_q + 11'h001;
        end
      end
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      loss_of_lock_flag_q <= 1'b0;
      irq_out             <= 1'b0;
    end else begin
      if (lol_event) begin
        loss_of_lock_flag_q <= 1'b1;
      end else if (wr_st && wdata_in[`ST_LOL]) begin
        loss_of_lock_flag_q <= 1'b0;
      end
      irq_out <= loss_of_lock_flag_q & loss_of_lock_irq_enable_q;
    end
  end

  // ------------------------------------------------------------
  // External reference monitor
  // ------------------------------------------------------------
  // only in external modes
  assign mon_enabled = clock_monitor_enable_q & ext_mode;

  // missing edges past the timeout fire a reset
  always @(posedge clk_in) begin
    if (!rst_b_in || !mon_enabled || ext_ref_tick_in) begin
      mon_count_q <= 16'h0000;
      mon_fire_q  <= 1'b0;
    end else if (mon_count_q >= MON_LIMIT - 16'h0001) begin
      mon_fire_q  <= 1'b1;
    end else begin
      mon_count_q <= mon_count_q + 16'h0001;
    end
  end

  // request out, error kept over system reset
  always @(posedge clk_in) begin
    if (!por_b_in) begin
      monitor_error_q <= 1'b0;
    end else if (mon_fire_q) begin
      monitor_error_q <= 1'b1;
    end else if (wr_st && wdata_in[`ST_MON_ERR]) begin
      monitor_error_q <= 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      reset_request_out      <= 1'b0;
      osc_enable_request_out <= 1'b0;
    end else begin
      reset_request_out      <= mon_fire_q | reset_request_out;
      // ask oscillator on while external reference used
      osc_enable_request_out <= ext_mode | ~ref_select_internal_q;
    end
  end

endmodule // clock_source_aux_control

// File: test/osc_ref_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// External oscillator stand-in
// ------------------------------------------------------------
module osc_ref_model (
  input  logic        clk_in,
  input  logic        osc_enable_req_in,
  input  logic        osc_enable_in,
  input  logic        osc_output_select_in,
  input  logic        pin_tick_in,
  input  logic [15:0] period_in,
  output logic        tick_out
);
  logic [15:0] cnt_q;
  logic        run;
  logic        xtl_tick;
  assign run = osc_enable_req_in || osc_enable_in;
  // Crystal tick counter, parked while off
  always @(posedge clk_in) begin
    if (!run || period_in == 16'h0000 || cnt_q >= period_in - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  assign xtl_tick = period_in != 16'h0000 && cnt_q == period_in - 16'h0001;
  assign tick_out = run && (osc_output_select_in ? xtl_tick : pin_tick_in);
endmodule // osc_ref_model

// File: test/clock_source_aux_props.sv
`timescale 1ns/10ps
`include "clock_source_aux_consts.vh"
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module clock_source_aux_props #(
  parameter MON_TIMEOUT_CYCLES = 20
) (
  input logic       clk_in,
  input logic       rst_b_in,
  input logic [2:0] addr_in,
  input logic [7:0] wdata_in,
  input logic       wr_in,
  input logic       debug_mode_in,
  input logic       stop_in,
  input logic       irc_output_clock_out,
  input logic       ffclk_valid_out,
  input logic       fll_enable_out,
  input logic       dco_up_out,
  input logic       dco_down_out,
  input logic       irq_out,
  input logic       reset_request_out,
  input logic       osc_enable_request_out
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [7:0] c4_q;
  logic       lp_byp;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Shadow of control registers from bus writes
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      c1_q <= `RST_CTRL1;
      c2_q <= `RST_CTRL2;
      c4_q <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == `OFS_CTRL1) c1_q <= wdata_in;
      if (addr_in == `OFS_CTRL2) c2_q <= wdata_in;
      if (addr_in == `OFS_CTRL4) c4_q <= wdata_in;
    end
  end
  // Low-power bypass mode in force
  assign lp_byp = c2_q[4] && !debug_mode_in && (c1_q[7:6] == 2'h1 || c1_q[7:6] == 2'h2);

  a_irc_gated: assert property (!c1_q[1] [*3] |-> !irc_output_clock_out)
    else $error("irc clock runs while disabled");
  a_irq_gated: assert property (!c4_q[7] [*3] |-> !irq_out)
    else $error("irq without enable");
  a_mon_needs_cme: assert property (!c4_q[5] [*3] |-> !$rose(reset_request_out))
    else $error("monitor reset without enable");
  a_mon_int_mode: assert property ((c1_q[7:6] == 2'h1) [*3] |-> !$rose(reset_request_out))
    else $error("monitor reset in internal bypass");
  a_req_sticky: assert property (reset_request_out |=> reset_request_out)
    else $error("reset request dropped");
  a_lp_fll_off: assert property (lp_byp [*4] |-> !fll_enable_out)
    else $error("fll on in low-power bypass");
  a_fll_kept_on: assert property ((!c2_q[4] && !stop_in) [*4] |-> fll_enable_out)
    else $error("fll off with power-down clear");
  a_lp_no_lock: assert property (lp_byp [*4] |-> !dco_up_out && !dco_down_out)
    else $error("lock logic active in low-power bypass");
  a_int_ff_invalid: assert property ((c1_q[7:6] == 2'h1) [*4] |-> !ffclk_valid_out)
    else $error("fixed clock valid in internal bypass");
  a_osc_request: assert property (!c1_q[2] [*3] |-> osc_enable_request_out)
    else $error("no oscillator request with external reference");

  c_irq: cover property (irq_out);
  c_mon_reset: cover property ($rose(reset_request_out));
  c_dco_down: cover property (dco_down_out);
endmodule // clock_source_aux_props

bind clock_source_aux_control clock_source_aux_props #(
  .MON_TIMEOUT_CYCLES(MON_TIMEOUT_CYCLES)
) u_clock_source_aux_props (
  .clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .debug_mode_in, .stop_in,
  .irc_output_clock_out, .ffclk_valid_out, .fll_enable_out, .dco_up_out, .dco_down_out,
  .irq_out, .reset_request_out, .osc_enable_request_out
);

// File: test/clock_source_aux_control_tb_top.sv
`timescale 1ns/10ps
`include "clock_source_aux_consts.vh"
module clock_source_aux_control_tb_top;
  logic        clk_in, rst_b_in, por_b_in, wr_in, rd_in, debug_mode_in, stop_in;
  logic        range_high_in, fll_tick_in, ext_ref_tick_in;
  logic [2:0]  addr_in;
  logic [7:0]  wdata_in, rdata_out;
  logic [8:0]  factory_trim_in;
  logic [15:0] ref_period;
  logic        main_output_clock_out, irc_output_clock_out, fixed_freq_clock_out;
  logic        ffclk_valid_out, fll_enable_out, dco_up_out, dco_down_out, irq_out;
  logic        reset_request_out, osc_enable_request_out;
  int          failures = 0, cmp_count = 0, n, i;
  localparam logic [55:0] C1V = 56'h04_00_44_44_80_80_44;
  localparam logic [27:0] C2V = 28'h000_1011;
  localparam logic [27:0] MV  = 28'h012_3452;

  clock_source_aux_control #(.MON_TIMEOUT_CYCLES(20)) u_clock_source_aux_control (
    .clk_in, .rst_b_in, .por_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .factory_trim_in, .debug_mode_in, .stop_in, .range_high_in, .ext_ref_tick_in,
    .fll_tick_in, .main_output_clock_out, .irc_output_clock_out, .fixed_freq_clock_out,
    .ffclk_valid_out, .fll_enable_out, .dco_up_out, .dco_down_out, .irq_out,
    .reset_request_out, .osc_enable_request_out);
  osc_ref_model u_osc_ref_model (.clk_in, .osc_enable_req_in(osc_enable_request_out),
    .osc_enable_in(1'b0), .osc_output_select_in(1'b1), .pin_tick_in(1'b0),
    .period_in(ref_period), .tick_out(ext_ref_tick_in));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task chk(input string w, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task rc(input string w, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(w, 16'(rdata_out & m), 16'(e));
    @(posedge clk_in);
  endtask
  // Cycles between two events; zero when none come
  task gap(input bit irc, output int g);
    int k, first;
    logic p;
    g = 0;
    first = -1;
    p = irc_output_clock_out;
    for (k = 0; k < 3000 && g == 0; k++) begin
      @(posedge clk_in);
      #1;
      if (irc ? irc_output_clock_out !== p : main_output_clock_out === 1'b1) begin
        if (first >= 0) g = k - first;
        first = k;
      end
      p = irc_output_clock_out;
    end
  endtask
  task gapchk(input string w, input bit irc, input int e);
    gap(irc, n);
    gap(irc, n);
    chk(w, 16'(n), 16'(e));
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Watchdog
  initial begin
    #400000;
    failures++;
    wrap_up;
  end
  // Main sequence
  initial begin
    {rst_b_in, por_b_in, wr_in, rd_in, debug_mode_in, stop_in} = 6'h00;
    {range_high_in, fll_tick_in} = 2'h3;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    factory_trim_in = 9'h0a5;
    ref_period = 16'h0000;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    por_b_in <= 1'b1;
    @(posedge clk_in);
    rc("ctrl1", `OFS_CTRL1, 8'hff, `RST_CTRL1);
    rc("ctrl2", `OFS_CTRL2, 8'hff, `RST_CTRL2);
    rc("trim", `OFS_TRIM, 8'hff, 8'h52); // coarse
    rc("fine", `OFS_CTRL4, 8'h01, 8'h01); // fine
    wr(3'h5, 8'hff);
    rc("unmapped", 3'h5, 8'hff, 8'h00);
    // Internal reference period and output divider
    // trim first, small divider after
    wr(`OFS_TRIM, 8'h10);
    wr(`OFS_CTRL1, 8'h46);
    wr(`OFS_CTRL2, 8'h00);
    gapchk("irc fast", 1'b1, 98); // small
    wr(`OFS_TRIM, 8'h20);
    gapchk("irc slow", 1'b1, 130); // large
    gapchk("out fbi", 1'b0, 130); // trim
    wr(`OFS_CTRL2, 8'h20);
    gapchk("out div2", 1'b0, 260); // divider
    wr(`OFS_CTRL2, 8'h00);
    gapchk("out div1", 1'b0, 130); // divider
    stop_in <= 1'b1;
    wr(`OFS_CTRL1, 8'h47);
    gapchk("irc in stop", 1'b1, 130); // kept
    wr(`OFS_CTRL1, 8'h46);
    gapchk("irc stopped", 1'b1, 0); // halted
    stop_in <= 1'b0;
    // Every mode, debug override last
    ref_period <= 16'd1024;
    for (i = 0; i < 7; i++) begin
      debug_mode_in <= (i == 6);
      wr(`OFS_CTRL1, C1V[8*(6-i) +: 8]);
      wr(`OFS_CTRL2, {3'h0, C2V[4*(6-i)], 4'h0});
      repeat (1100) @(posedge clk_in);
      rc("mode", `OFS_STATUS, 8'h0e, {4'h0, MV[4*(6-i) +: 3], 1'b0});
      chk("fll on", 16'(fll_enable_out), 16'(MV[4*(6-i) +: 3] % 2 == 0 || i < 3));
    end
    debug_mode_in <= 1'b0;
    // Fixed clock limits in external bypass
    for (i = 0; i < 8; i++) begin
      wr(`OFS_CTRL2, {3'(i / 2), 5'h00});
      wr(`OFS_CTRL1, {2'b10, 3'(i / 2 + 1 + i % 2), 3'b000});
      repeat (1100) @(posedge clk_in);
      #1 chk("ff valid", 16'(ffclk_valid_out), 16'(i % 2));
    end
    // Lock on external reference, then lose it
    wr(`OFS_CTRL1, 8'h00);
    wr(`OFS_CTRL4, 8'h01);
    repeat (3100) @(posedge clk_in);
    wr(`OFS_STATUS, 8'h80);
    rc("locked", `OFS_STATUS, 8'hc0, 8'h40); // lock
    #1 n = fixed_freq_clock_out;
    repeat (1024) @(posedge clk_in);
    #1 chk("ff clock", 16'(fixed_freq_clock_out), 16'(n == 0)); // toggles
    chk("irq masked", 16'(irq_out), 16'h0); // mask
    wr(`OFS_CTRL4, 8'h81);
    ref_period <= 16'd1200;
    repeat (2500) @(posedge clk_in);
    rc("lol set", `OFS_STATUS, 8'h80, 8'h80); // flag
    chk("irq", 16'(irq_out), 16'h1); // raise
    chk("no monitor", 16'(reset_request_out), 16'h0); // off
    chk("osc req", 16'(osc_enable_request_out), 16'h1); // external
    wr(`OFS_STATUS, 8'h00);
    rc("lol kept", `OFS_STATUS, 8'h80, 8'h80); // zero
    wr(`OFS_STATUS, 8'h80);
    rc("lol clear", `OFS_STATUS, 8'h80, 8'h00); // one
    chk("irq gone", 16'(irq_out), 16'h0); // follow
    // Clock monitor
    wr(`OFS_CTRL1, 8'h44);
    repeat (1100) @(posedge clk_in);
    wr(`OFS_CTRL4, 8'h21);
    repeat (60) @(posedge clk_in);
    #1 chk("mon internal", 16'(reset_request_out), 16'h0); // mode
    chk("osc idle", 16'(osc_enable_request_out), 16'h0); // internal
    ref_period <= 16'd30;
    wr(`OFS_CTRL1, 8'h00);
    repeat (1100) @(posedge clk_in);
    #1 chk("mon fired", 16'(reset_request_out), 16'h1); // reset
    rc("mon err", `OFS_STATUS, 8'h20, 8'h20); // error
    rst_b_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    #1 chk("req cleared", 16'(reset_request_out), 16'h0); // reset
    rc("err kept", `OFS_STATUS, 8'ha0, 8'h20); // survive
    por_b_in <= 1'b0;
    @(posedge clk_in);
    por_b_in <= 1'b1;
    @(posedge clk_in);
    rc("err gone", `OFS_STATUS, 8'h20, 8'h00); // power-on
    wrap_up;
  end
endmodule // clock_source_aux_control_tb_top
